/* logic/gec_pkg.sv */
// Shared constants for the port, edge interrupt and serial frame control slice.
package gec_pkg;

  // ----------------------------------------------------------------------
  // Register addresses carried in the control word
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_PORT_VALUE = 4'h0;
  localparam logic [3:0] ADDR_PORT_DIR = 4'h1;
  localparam logic [3:0] ADDR_RISE_EN = 4'h2;
  localparam logic [3:0] ADDR_FALL_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int PORT_W = 10;
  localparam int BIT_FORCE_LOW = 15;
  localparam int BIT_CONV = 11;
  localparam int BIT_POS_X = 12;
  localparam int BIT_NEG_X = 13;
  localparam logic [15:0] SRC_MASK = 16'h3bff;
  localparam logic [15:0] DIR_MASK = 16'h83ff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [9:0] PORT_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // Serial frame layout, bit indices within a 64-bit frame
  // ----------------------------------------------------------------------
  localparam logic [5:0] FRAME_LAST = 6'h3f;
  localparam logic [5:0] WORD1_LAST = 6'h0f;
  localparam logic [5:0] WORD2_FIRST = 6'h10;
  localparam logic [5:0] WORD2_LAST = 6'h1f;
  localparam logic [5:0] WORD3_FIRST = 6'h20;
  localparam logic [5:0] WORD3_LAST = 6'h2f;
  localparam int CTRL_WR_POS = 15;
  localparam int CTRL_ADDR_HI = 14;
  localparam int CTRL_ADDR_LO = 11;

  // ----------------------------------------------------------------------
  // Reset stretching and synchroniser width
  // ----------------------------------------------------------------------
  localparam logic [2:0] RST_SCLK_PERIODS = 3'h5;
  localparam int SYNC_W = 17;

endpackage

/* logic/gec_sync.sv */
// Two-flop synchroniser bank for inputs from outside the mclk domain.
`timescale 1ns/1ps
module gec_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

/* logic/gec_rst_gen.sv */
// Internal reset stretcher counting serial clock periods after the reset pin releases.
`timescale 1ns/1ps
module gec_rst_gen (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic extRstN,
  input wire logic sclkRise,
  output logic intRst_q
);
  import gec_pkg::*;

  logic [2:0] cnt_q;

  // The pulse outlasts the pin so that registers clear even on a glitch-short reset.
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !extRstN)
    begin
      cnt_q <= 3'h0;
      intRst_q <= 1'b1;
    end
    else if (intRst_q && sclkRise)
    begin
      cnt_q <= cnt_q + 3'h1;
      intRst_q <= (cnt_q + 3'h1) != RST_SCLK_PERIODS;
    end
  end

endmodule

/* logic/gec_ctrl.sv */
// Port, edge interrupt and serial frame register slice, top level.
//
// Functional notes
// - Output pins drive the last value written to the port value register.
// - Reading the port value register returns the sensed pin levels.
// - Direction bit one makes the pin an output, zero disables its driver.
// - Reset clears all direction and port value bits.
// - Force-low bit set drives serial output low through the second word.
// - Force-low bit clear floats serial output during the second word.
// - Port pin rising edges interrupt only when enabled; enables reset to zero.
// - Enable bit 11 lets converter-done rising edges interrupt.
// - Enable bit 12 lets positive-x plate rising edges interrupt.
// - Enable bit 13 lets negative-x plate rising edges interrupt.
// - External reset makes an internal reset lasting five serial clock periods.
// - Falling-edge enable register at address 3 works bit for bit.
// - Writing address 4 clears a pending flag on a zero-to-one bit change.
// - Reading address 4 returns the pending flags.
`timescale 1ns/1ps
module gec_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sibClk,
  input wire logic sibSync,
  input wire logic sibDataIn,
  output logic serialDataOutput,
  output logic serialDataOutputOe,
  input wire logic [gec_pkg::PORT_W-1:0] portPinIn,
  output logic [gec_pkg::PORT_W-1:0] portPinOut,
  output logic [gec_pkg::PORT_W-1:0] portPinOe,
  input wire logic convDone,
  input wire logic touchPlatePosX,
  input wire logic touchPlateNegX,
  input wire logic extRstN
);
  import gec_pkg::*;

  function automatic logic [15:0] riseOf(input logic [15:0] cur, input logic [15:0] prev);
    riseOf = cur & ~prev;
  endfunction

  // ----------------------------------------------------------------------
  // Synchronisers and serial clock edges
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] syncOut;
  logic [PORT_W-1:0] sIo;
  logic sConv, sPosX, sNegX, sClk, sSync, sDin, sRstN;
  logic sclkPrev_q;
  logic sclkRise, sclkFall, intRst, rstAll;

  gec_sync #(.W(SYNC_W)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .asyncIn({extRstN, sibDataIn, sibSync, sibClk, touchPlateNegX, touchPlatePosX,
              convDone, portPinIn}),
    .syncOut(syncOut)
  );

  assign {sRstN, sDin, sSync, sClk, sNegX, sPosX, sConv, sIo} = syncOut;
  assign sclkRise = sClk && !sclkPrev_q;
  assign sclkFall = !sClk && sclkPrev_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sclkPrev_q <= 1'b0;
    else
      sclkPrev_q <= sClk;
  end

  gec_rst_gen u_rst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .extRstN(sRstN),
    .sclkRise(sclkRise),
    .intRst_q(intRst)
  );

  assign rstAll = sys_rst || intRst;

  // ----------------------------------------------------------------------
  // Serial frame tracking
  // ----------------------------------------------------------------------
  logic [5:0] bitCnt_q, sampBit, outBit, rdDiff;
  logic inFrame_q, sampValid;
  logic [15:0] shift_q, shiftNext, rdData_q, rdMux;
  logic ctrlWr_q;
  logic [3:0] ctrlAddr_q, addrNext;
  logic wrEn;
  logic [15:0] wrData;

  assign sampBit = sSync ? 6'h00 : bitCnt_q + 6'h01;
  assign sampValid = sSync || (inFrame_q && bitCnt_q != FRAME_LAST);
  assign shiftNext = {shift_q[14:0], sDin};
  assign addrNext = shiftNext[CTRL_ADDR_HI:CTRL_ADDR_LO];
  assign wrEn = sclkFall && sampValid && sampBit == WORD2_LAST && ctrlWr_q;
  assign wrData = shiftNext;
  assign outBit = bitCnt_q + 6'h01;
  assign rdDiff = WORD3_LAST - outBit;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bitCnt_q <= FRAME_LAST;
      inFrame_q <= 1'b0;
      shift_q <= 16'h0000;
    end
    else if (sclkFall)
    begin
      shift_q <= shiftNext;
      bitCnt_q <= sampValid ? sampBit : bitCnt_q;
      inFrame_q <= sampValid && sampBit != FRAME_LAST;
    end
  end

  // Read data is frozen when the control word ends, so pins may move during shift-out.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrlWr_q <= 1'b0;
      ctrlAddr_q <= 4'h0;
      rdData_q <= 16'h0000;
    end
    else if (sclkFall && sampValid && sampBit == WORD1_LAST)
    begin
      ctrlWr_q <= shiftNext[CTRL_WR_POS];
      ctrlAddr_q <= addrNext;
      rdData_q <= rdMux;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [PORT_W-1:0] valueReg_q;
  logic [15:0] dirReg_q, riseEn_q, fallEn_q, lastClr_q, pend_q;
  logic wrValue, wrDir, wrRise, wrFall, wrClr, forceLow;

  assign wrValue = wrEn && ctrlAddr_q == ADDR_PORT_VALUE;
  assign wrDir = wrEn && ctrlAddr_q == ADDR_PORT_DIR;
  assign wrRise = wrEn && ctrlAddr_q == ADDR_RISE_EN;
  assign wrFall = wrEn && ctrlAddr_q == ADDR_FALL_EN;
  assign wrClr = wrEn && ctrlAddr_q == ADDR_IRQ_CLR;
  assign forceLow = dirReg_q[BIT_FORCE_LOW];

  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      valueReg_q <= PORT_RESET;
      dirReg_q <= REG_RESET;
      riseEn_q <= REG_RESET;
      fallEn_q <= REG_RESET;
      lastClr_q <= REG_RESET;
    end
    else
    begin
      if (wrValue)
        valueReg_q <= wrData[PORT_W-1:0];
      if (wrDir)
        dirReg_q <= wrData & DIR_MASK;
      if (wrRise)
        riseEn_q <= wrData & SRC_MASK;
      if (wrFall)
        fallEn_q <= wrData & SRC_MASK;
      if (wrClr)
        lastClr_q <= wrData & SRC_MASK;
    end
  end

  // Unmapped addresses and unused bit positions read as zero.
  assign rdMux = (addrNext == ADDR_PORT_VALUE) ? {6'h00, sIo} :
                 (addrNext == ADDR_PORT_DIR) ? dirReg_q :
                 (addrNext == ADDR_RISE_EN) ? riseEn_q :
                 (addrNext == ADDR_FALL_EN) ? fallEn_q :
                 (addrNext == ADDR_IRQ_CLR) ? pend_q : 16'h0000;

  // ----------------------------------------------------------------------
  // Edge interrupt sources
  // ----------------------------------------------------------------------
  logic [15:0] srcNow, srcPrev_q, risen, fallen, setVec, clrVec, pend_d;

  assign srcNow = {2'h0, sNegX, sPosX, sConv, 1'b0, sIo} & SRC_MASK;
  assign risen = sclkRise ? riseOf(srcNow, srcPrev_q) : 16'h0000;
  assign fallen = sclkRise ? riseOf(srcPrev_q, srcNow) : 16'h0000;
  assign setVec = (risen & riseEn_q) | (fallen & fallEn_q);
  assign clrVec = wrClr ? riseOf(wrData & SRC_MASK, lastClr_q) : 16'h0000;
  // A new edge in the clearing cycle survives the clear.
  assign pend_d = (pend_q & ~clrVec) | setVec;

  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      srcPrev_q <= REG_RESET;
      pend_q <= REG_RESET;
    end
    else
    begin
      if (sclkRise)
        srcPrev_q <= srcNow;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin and serial output drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rstAll)
    begin
      portPinOut <= PORT_RESET;
      portPinOe <= PORT_RESET;
    end
    else
    begin
      portPinOut <= valueReg_q;
      portPinOe <= dirReg_q[PORT_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      serialDataOutput <= 1'b0;
      serialDataOutputOe <= 1'b0;
    end
    else if (sclkRise)
    begin
      if (inFrame_q && outBit >= WORD2_FIRST && outBit <= WORD2_LAST)
      begin
        serialDataOutput <= 1'b0;
        serialDataOutputOe <= forceLow;
      end
      else if (inFrame_q && !ctrlWr_q && outBit >= WORD3_FIRST && outBit <= WORD3_LAST)
      begin
        serialDataOutput <= rdData_q[rdDiff[3:0]];
        serialDataOutputOe <= 1'b1;
      end
      else
      begin
        serialDataOutput <= 1'b0;
        serialDataOutputOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic inWord2;
  assign inWord2 = sclkRise && inFrame_q && outBit >= WORD2_FIRST && outBit <= WORD2_LAST;

  sequence s_write_dir;
    wrDir && !rstAll ##1 !rstAll;
  endsequence

  property p_value_drives;
    wrValue && !rstAll ##1 !rstAll |=> portPinOut == $past(wrData[PORT_W-1:0], 2);
  endproperty
  a_value_drives: assert property (p_value_drives) else $error("Pin out not written value.");

  property p_dir_enables;
    s_write_dir |=> portPinOe == $past(wrData[PORT_W-1:0], 2);
  endproperty
  a_dir_enables: assert property (p_dir_enables) else $error("Pin enable not direction.");

  property p_reset_clears;
    rstAll |=> dirReg_q == 16'h0000 && valueReg_q == 10'h000 ##1 portPinOe == 10'h000;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("Reset left port bits set.");

  property p_force_low;
    inWord2 && forceLow |=> serialDataOutputOe && !serialDataOutput;
  endproperty
  a_force_low: assert property (p_force_low) else $error("Second word not forced low.");

  property p_float;
    inWord2 && !forceLow |=> !serialDataOutputOe;
  endproperty
  a_float: assert property (p_float) else $error("Second word not floated.");

  property p_no_irq_disabled;
    !rstAll && pend_q == 16'h0000 && riseEn_q == 16'h0000 && fallEn_q == 16'h0000
      |=> pend_q == 16'h0000;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("Irq without enable.");

  property p_conv_rise;
    !rstAll && risen[BIT_CONV] && riseEn_q[BIT_CONV] |=> pend_q[BIT_CONV];
  endproperty
  a_conv_rise: assert property (p_conv_rise) else $error("Converter edge lost.");

  property p_posx_rise;
    !rstAll && risen[BIT_POS_X] && riseEn_q[BIT_POS_X] |=> pend_q[BIT_POS_X];
  endproperty
  a_posx_rise: assert property (p_posx_rise) else $error("Positive-x edge lost.");

  property p_negx_rise;
    !rstAll && risen[BIT_NEG_X] && riseEn_q[BIT_NEG_X] |=> pend_q[BIT_NEG_X];
  endproperty
  a_negx_rise: assert property (p_negx_rise) else $error("Negative-x edge lost.");

  property p_ext_reset;
    !sRstN |=> intRst [*2];
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("Internal reset missing.");

  property p_fall_sets;
    !rstAll && (fallen & fallEn_q) != 16'h0000
      |=> (pend_q & $past(fallen & fallEn_q)) == $past(fallen & fallEn_q);
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("Falling edge lost.");

  property p_clear;
    !rstAll && (clrVec & ~setVec) != 16'h0000 |=> (pend_q & $past(clrVec & ~setVec)) == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("Pending flag not cleared.");

  property p_sticky;
    !rstAll && pend_q[BIT_CONV] && !clrVec[BIT_CONV] |=> pend_q[BIT_CONV];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Pending flag dropped.");

  property p_unused_zero;
    ((riseEn_q | fallEn_q | pend_q) & ~SRC_MASK) == 16'h0000 && (dirReg_q & ~DIR_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set.");

endmodule

/* testbench/gec_sib_host.sv */
// System controller model that runs frames on the serial interface bus.
`timescale 1ns/1ps
module gec_sib_host (
  output logic sibClk,
  output logic sibSync,
  output logic sibDataIn,
  input wire logic sdoPin
);
  initial
  begin
    sibClk = 1'b0;
    sibSync = 1'b0;
    sibDataIn = 1'b0;
  end

  // --------------------------------------------------------------------
  // Frame and pause tasks
  // --------------------------------------------------------------------
  // The serial clock stands still between frames, so pauses are clocked on purpose.
  task automatic idle(input int n);
    repeat (n)
    begin
      #32 sibClk = 1'b1;
      #2 sibDataIn = ~sibDataIn;
      #30 sibClk = 1'b0;
    end
  endtask

  // Ignored bits carry the inverse of the previous bit, so stale data never looks valid.
  task automatic frame(input logic wr, input logic [3:0] addr, input logic [15:0] wdat,
    output logic [15:0] rdat, output logic [15:0] w2);
    logic [15:0] word1;
    word1 = {wr, addr, 11'h000};
    for (int i = 0; i < 64; i++)
    begin
      #31 sibClk = 1'b1;
      #2 sibSync = (i == 0);
      if (i < 5)
        sibDataIn = word1[15-i];
      else if (wr && i >= 16 && i < 32)
        sibDataIn = wdat[31-i];
      else
        sibDataIn = ~sibDataIn;
      #30 sibClk = 1'b0;
      #1;
      if (i >= 16 && i < 32)
        w2[31-i] = sdoPin;
      if (i >= 32 && i < 48)
        rdat[47-i] = sdoPin;
    end
    sibSync = 1'b0;
  endtask
endmodule

/* testbench/gec_ctrl_tb.sv */
// Self-checking bench for the port, edge interrupt and serial frame slice.
`timescale 1ns/1ps
module gec_ctrl_tb;
  import gec_pkg::*;
  logic mclk, sys_rst, extRstN, convDone, touchPlatePosX, touchPlateNegX;
  logic [PORT_W-1:0] portPinIn, portPinOut, portPinOe;
  logic sibClk, sibSync, sibDataIn, serialDataOutput, serialDataOutputOe;
  logic [15:0] rd, w2;
  wire sdoPin = serialDataOutputOe ? serialDataOutput : 1'bz;
  int errCount = 0;
  int samplesChecked = 0;

  gec_ctrl dut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sibClk(sibClk),
    .sibSync(sibSync),
    .sibDataIn(sibDataIn),
    .serialDataOutput(serialDataOutput),
    .serialDataOutputOe(serialDataOutputOe),
    .portPinIn(portPinIn),
    .portPinOut(portPinOut),
    .portPinOe(portPinOe),
    .convDone(convDone),
    .touchPlatePosX(touchPlatePosX),
    .touchPlateNegX(touchPlateNegX),
    .extRstN(extRstN)
  );
  gec_sib_host host (
    .sibClk(sibClk),
    .sibSync(sibSync),
    .sibDataIn(sibDataIn),
    .sdoPin(sdoPin)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.frame(1'b1, a, d, rd, w2);
  endtask

  task automatic rdReg(input logic [3:0] a, input logic [15:0] exp);
    host.frame(1'b0, a, 16'h0000, rd, w2);
    chk(rd, exp);
  endtask

  task automatic setSrc(input logic v);
    @(posedge mclk);
    portPinIn <= {PORT_W{v}};
    convDone <= v;
    touchPlatePosX <= v;
    touchPlateNegX <= v;
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    rdReg(ADDR_PORT_VALUE, 16'h0000);
    rdReg(ADDR_PORT_DIR, 16'h0000);
    rdReg(ADDR_RISE_EN, 16'h0000);
    rdReg(ADDR_FALL_EN, 16'h0000);
    rdReg(ADDR_IRQ_CLR, 16'h0000);
    rdReg(4'h5, 16'h0000);
    chk(w2, 16'hzzzz);
    chk({6'h00, portPinOe}, 16'h0000);
    chk({6'h00, portPinOut}, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_port();
    wr(ADDR_PORT_DIR, 16'hffff);
    rdReg(ADDR_PORT_DIR, 16'h83ff);
    chk(w2, 16'h0000);
    chk({6'h00, portPinOe}, 16'h03ff);
    wr(ADDR_PORT_VALUE, 16'hfea5);
    chk({6'h00, portPinOut}, 16'h02a5);
    // Pins are fed the inverse of what is driven, so a read of the stored value would show.
    @(posedge mclk) portPinIn <= ~portPinOut;
    rdReg(ADDR_PORT_VALUE, 16'h015a);
    wr(ADDR_PORT_DIR, 16'h0005);
    chk({6'h00, portPinOe}, 16'h0005);
    rdReg(ADDR_PORT_DIR, 16'h0005);
    chk(w2, 16'hzzzz);
    $display("port test done");
  endtask

  task automatic t_irq();
    setSrc(1'b0);
    wr(ADDR_RISE_EN, 16'hffff);
    rdReg(ADDR_RISE_EN, 16'h3bff);
    rdReg(ADDR_IRQ_CLR, 16'h0000);
    setSrc(1'b1);
    host.idle(3);
    rdReg(ADDR_IRQ_CLR, 16'h3bff);
    host.idle(8);
    rdReg(ADDR_IRQ_CLR, 16'h3bff);
    wr(ADDR_IRQ_CLR, 16'h3bff);
    rdReg(ADDR_IRQ_CLR, 16'h0000);
    wr(ADDR_RISE_EN, 16'h1001);
    wr(ADDR_FALL_EN, 16'h0802);
    setSrc(1'b0);
    host.idle(3);
    rdReg(ADDR_IRQ_CLR, 16'h0802);
    wr(ADDR_IRQ_CLR, 16'h0000);
    rdReg(ADDR_IRQ_CLR, 16'h0802);
    wr(ADDR_IRQ_CLR, 16'h0802);
    rdReg(ADDR_IRQ_CLR, 16'h0000);
    setSrc(1'b1);
    host.idle(3);
    rdReg(ADDR_IRQ_CLR, 16'h1001);
    $display("interrupt test done");
  endtask

  task automatic t_extrst();
    @(posedge mclk) extRstN <= 1'b0;
    repeat (10) @(posedge mclk);
    extRstN <= 1'b1;
    repeat (5) @(negedge mclk);
    chk({6'h00, portPinOe}, 16'h0000);
    host.idle(6);
    rdReg(ADDR_RISE_EN, 16'h0000);
    rdReg(ADDR_PORT_DIR, 16'h0000);
    rdReg(ADDR_IRQ_CLR, 16'h0000);
    $display("external reset test done");
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    extRstN = 1'b1;
    convDone = 1'b0;
    touchPlatePosX = 1'b0;
    touchPlateNegX = 1'b0;
    portPinIn = '0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    host.idle(6);
    t_reset();
    t_port();
    t_irq();
    t_extrst();
    giveVerdict();
  end

  initial
  begin
    #300us;
    errCount++;
    $display("[FAIL] %0t run did not finish", $time);
    giveVerdict();
  end
endmodule
